// file: irq_clk_pkg.sv
// shared constants and carriers for the interrupt combiner and clock-loss status block
package irq_clk_pkg;

   // register map, word addresses on the internal register port
   localparam logic [9:0] ADDR_WIDTH_T_DUMMY = 10'h000;
   localparam int         REG_ADDR_W         = 10;
   localparam int         REG_DATA_W         = 16;
   localparam logic [9:0] CLK_STATUS_ADDR    = 10'h1c7;
   localparam logic [9:0] IRQ_STATUS_ADDR    = 10'h1d4;

   // interrupt status word field positions
   localparam int ST_HALT_LSB  = 0;
   localparam int ST_CORE_LSB  = 4;
   localparam int ST_DRV_BIT   = 8;
   localparam int ST_SPI_BIT   = 9;
   localparam int ST_CKSYS_BIT = 10;
   localparam int ST_SIG_A_BIT = 11;
   localparam int ST_SIG_B_BIT = 12;
   localparam int ST_USED_W    = 13;

   // clock status register field positions
   localparam int CS_LOSS_BIT   = 0;
   localparam int CS_RETURN_BIT = 1;
   localparam int CS_HOST_EN    = 2;
   localparam int CS_CORE_EN_LSB = 3;
   localparam int CS_DRV_DIS    = 7;
   localparam int CS_TIMING_BIT = 8;

   // reset values
   localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
   localparam logic [5:0]  CLK_CFG_RESET    = 6'h00;
   localparam logic        IRQ_N_RESET      = 1'b1;
   localparam logic        DRV_EN_RESET     = 1'b1;

   // requests entering the combiner, one bit per status bit
   typedef struct packed {
      logic       sig_err_b;
      logic       sig_err_a;
      logic       cksys_missing;
      logic       spi_error;
      logic       drv_off;
      logic [3:0] core_request;   // core1_b, core0_b, core1_a, core0_a
      logic [3:0] short_halt;     // same order as above
   } irq_src_s;

   // software-written clock-loss configuration
   typedef struct packed {
      logic       drv_disable;
      logic [3:0] core_enable;    // core1_b, core0_b, core1_a, core0_a
      logic       host_enable;
   } clk_cfg_s;

endpackage : irq_clk_pkg

// file: irq_clk_combiner.sv
// interrupt combiner with latched cause word and clock-loss status/control register
// Operation
// - host interrupt pin driven low while any enabled source requests
// - cause word captured from all sources when the pin asserts
// - cause word holds while the pin stays asserted
// - pin released and cause word cleared once no source requests
// - host reads cause word over the serial register port
// - sources: four cores, driver shutdown, serial error, clock loss, code signature
// - bits 0-3 latch short-circuit halts of the four cores
// - bits 4-7 latch the four core program interrupt requests
// - bit 8 latches driver shutdown
// - bit 9 serial error, bit 10 host clock-loss request
// - bits 11 and 12 latch code signature errors of both channels
// - timing violation flag set by hardware, cleared by writing one
// - read-only loss flag holds until clock returns and return requested
// - return request rising during loss holds until switch-back, then clears
// - return request without loss clears at once with no effect
// - host clock-loss interrupt stays until clock status register read
// - four enables steer clock-loss interrupts to the four cores
// - driver-disable option forces drivers off while clock loss persists
// - clock-loss interrupts fire on switch to internal and on return attempts
// - core sees clock-loss interrupt only with a valid external clock
`timescale 1ns/10ps
module irq_clk_combiner
   import irq_clk_pkg::*;
#(
   parameter int NUM_CORES = 4
) (
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   // register port from the serial interface
   input  wire logic [REG_ADDR_W-1:0] reg_addr,
   input  wire logic                  reg_wr_en,
   input  wire logic                  reg_rd_en,
   input  wire logic [REG_DATA_W-1:0] reg_wdata,
   output logic      [REG_DATA_W-1:0] reg_rdata,
   // interrupt sources
   input  wire logic [3:0]            short_halt,
   input  wire logic [3:0]            core_request,
   input  wire logic                  drv_off,
   input  wire logic                  spi_error,
   input  wire logic                  code_sig_error_a,
   input  wire logic                  code_sig_error_b,
   // clock manager side
   input  wire logic                  ref_clock_lost,
   input  wire logic                  switched_to_internal,
   input  wire logic                  switched_to_external,
   input  wire logic                  ext_clk_valid,
   input  wire logic                  cksys_missing,
   input  wire logic                  timing_violation_evt,
   input  wire logic [3:0]            core_clkloss_ack,
   // outputs
   output logic                       host_irq_out_n,
   output logic                       return_to_ext_ref,
   output logic [3:0]                 core_clkloss_irq,
   output logic                       cksys_drv_en
);

   // the four core lanes are wired into fixed status positions
   if (NUM_CORES != 4) begin : g_bad_cores
      $error("irq_clk_combiner supports exactly four cores");
   end

   function automatic logic hit(input logic [REG_ADDR_W-1:0] a,
                                input logic [REG_ADDR_W-1:0] target);
      return a == target;
   endfunction : hit

   logic     irq_n_q;
   logic     [REG_DATA_W-1:0] status_q;
   logic     [REG_DATA_W-1:0] rdata_q;
   clk_cfg_s cfg_q;
   logic     loss_q;
   logic     return_q;
   logic     timing_q;
   logic     host_cl_irq_q;
   logic     [3:0] core_pend_q;
   logic     [3:0] core_irq_q;
   logic     drv_en_q;
   irq_src_s src;
   logic     [ST_USED_W-1:0] src_vec;
   logic     any_req;
   logic     wr_clk;
   logic     rd_clk;
   logic     ret_rise;
   logic     cl_event;

   // strobes decoded once; a read of the clock register also drops the host request
   assign wr_clk = reg_wr_en && hit(reg_addr, CLK_STATUS_ADDR);
   assign rd_clk = reg_rd_en && hit(reg_addr, CLK_STATUS_ADDR);
   // a one written over a zero is the rising edge of the return request
   assign ret_rise = wr_clk && reg_wdata[CS_RETURN_BIT] && !return_q;
   // clock-loss event: switch to internal or a serial return attempt
   assign cl_event = switched_to_internal || (ret_rise && loss_q);

   // gather the sources into status order
   always_comb begin
      src.short_halt    = short_halt;
      src.core_request  = core_request;
      src.drv_off       = drv_off;
      src.spi_error     = spi_error;
      src.cksys_missing = host_cl_irq_q;
      src.sig_err_a     = code_sig_error_a;
      src.sig_err_b     = code_sig_error_b;
   end
   assign src_vec = src;
   assign any_req = |src_vec;

   // interrupt pin: low while anything requests
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_n_q <= IRQ_N_RESET;
      end else begin
         irq_n_q <= !any_req;
      end
   end

   // cause word: snapshot on assertion, frozen while asserted, cleared on release
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= IRQ_STATUS_RESET;
      end else if (!any_req) begin
         status_q <= IRQ_STATUS_RESET;
      end else if (irq_n_q) begin
         status_q <= {{(REG_DATA_W-ST_USED_W){1'b0}}, src_vec};
      end
      // otherwise hold: later requests do not disturb the word
   end

   // software configuration bits; writes to the cause word fall through
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q <= CLK_CFG_RESET;
      end else if (wr_clk) begin
         cfg_q.host_enable <= reg_wdata[CS_HOST_EN];
         cfg_q.core_enable <= reg_wdata[CS_CORE_EN_LSB +: 4];
         cfg_q.drv_disable <= reg_wdata[CS_DRV_DIS];
      end
   end

   // timing violation: set wins over the write-one clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         timing_q <= 1'b0;
      end else if (timing_violation_evt) begin
         timing_q <= 1'b1;
      end else if (wr_clk && reg_wdata[CS_TIMING_BIT]) begin
         timing_q <= 1'b0;
      end
   end

   // loss flag: only cleared by a completed return to the external reference
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         loss_q <= 1'b0;
      end else if (ref_clock_lost) begin
         loss_q <= 1'b1;
      end else if (switched_to_external && return_q && ext_clk_valid) begin
         loss_q <= 1'b0;
      end
   end

   // return request: held during loss until switch-back; never set otherwise
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         return_q <= 1'b0;
      end else if (ret_rise && loss_q) begin
         return_q <= 1'b1;
      end else if (return_q && (switched_to_external || !loss_q)) begin
         return_q <= 1'b0;
      end
   end

   // host clock-loss request: held until the status register is read
   // the event wins a tie with the read so none is lost
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_cl_irq_q <= 1'b0;
      end else if (cl_event && cfg_q.host_enable) begin
         host_cl_irq_q <= 1'b1;
      end else if (rd_clk) begin
         host_cl_irq_q <= 1'b0;
      end
   end

   // per-core pending requests, released only with a valid external clock
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         core_pend_q <= 4'h0;
         core_irq_q  <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (cl_event && cfg_q.core_enable[i]) begin
               core_pend_q[i] <= 1'b1;
            end else if (core_clkloss_ack[i]) begin
               core_pend_q[i] <= 1'b0;
            end
         end
         // gating after the pending flag keeps a request waiting, not lost
         core_irq_q <= core_pend_q & {4{ext_clk_valid}};
      end
   end

   // drivers forced off while the system clock is missing, if so chosen
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         drv_en_q <= DRV_EN_RESET;
      end else begin
         // one cycle of lag is harmless against a relock time of many microseconds
         drv_en_q <= !(cfg_q.drv_disable && cksys_missing);
      end
   end

   // registered read data, answers one cycle after the strobe
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 16'h0000;
      end else if (reg_rd_en) begin
         if (hit(reg_addr, IRQ_STATUS_ADDR)) begin
            rdata_q <= status_q;
         end else if (hit(reg_addr, CLK_STATUS_ADDR)) begin
            rdata_q <= {7'h00, timing_q, cfg_q.drv_disable, cfg_q.core_enable,
                        cfg_q.host_enable, return_q, loss_q};
         end else begin
            rdata_q <= 16'h0000;
         end
      end
   end

   assign host_irq_out_n    = irq_n_q;
   assign reg_rdata         = rdata_q;
   assign return_to_ext_ref = return_q;
   assign core_clkloss_irq  = core_irq_q;
   assign cksys_drv_en      = drv_en_q;

   // checks on the logic above
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_first_req;
      any_req && irq_n_q;
   endsequence

   sequence s_pin_low;
      !host_irq_out_n;
   endsequence

   pin_follows_req_a: assert property (any_req |=> !host_irq_out_n)
      else $error("interrupt pin not low after a request");

   capture_on_assert_a: assert property (s_first_req |=> s_pin_low ##0
                                         status_q[12:0] == $past(src_vec))
      else $error("cause word not captured at assertion");

   word_frozen_a: assert property (any_req && !irq_n_q |=> $stable(status_q))
      else $error("cause word changed while pin asserted");

   release_clear_a: assert property (!any_req |=> host_irq_out_n && status_q == 16'h0000)
      else $error("pin or cause word not released");

   cause_read_a: assert property (reg_rd_en && reg_addr == IRQ_STATUS_ADDR
                                  |=> reg_rdata == $past(status_q))
      else $error("cause word read returned wrong value");

   timing_clear_a: assert property (wr_clk && reg_wdata[CS_TIMING_BIT] && !timing_violation_evt
                                    |=> !timing_q)
      else $error("timing flag not cleared by write");

   loss_sticky_a: assert property (loss_q && !switched_to_external |=> loss_q)
      else $error("loss flag cleared without switch-back");

   return_noloss_a: assert property (wr_clk && reg_wdata[CS_RETURN_BIT] && !loss_q
                                     |=> !return_to_ext_ref)
      else $error("return request stuck without loss");

   host_hold_a: assert property (host_cl_irq_q && !rd_clk |=> host_cl_irq_q)
      else $error("host clock-loss request dropped before read");

   drv_off_a: assert property (cfg_q.drv_disable && cksys_missing |=> !cksys_drv_en)
      else $error("drivers not forced off during clock loss");

   core_gate_a: assert property (!ext_clk_valid |=> core_clkloss_irq == 4'h0)
      else $error("core interrupt without valid clock");

   upper_zero_a: assert property (status_q[15:13] == 3'h0)
      else $error("reserved cause bits set");

   // return request armed: a one written during loss, none pending yet
   sequence s_return_armed;
      ret_rise && loss_q;
   endsequence

   // switch-back completes while the return request is pending
   sequence s_switch_back;
      return_q && switched_to_external;
   endsequence

   // a clock-loss event with the host enable set
   sequence s_host_event;
      cl_event && cfg_q.host_enable;
   endsequence

   return_set_a: assert property (s_return_armed |=> return_to_ext_ref)
      else $error("return request not held during loss");

   return_hold_a: assert property (s_return_armed ##1 !switched_to_external
                                   |=> return_to_ext_ref)
      else $error("return request dropped before switch-back");

   return_clear_a: assert property (s_switch_back |=> !return_to_ext_ref)
      else $error("return request not cleared after switch-back");

   loss_clear_a: assert property (s_switch_back ##0 (ext_clk_valid && !ref_clock_lost)
                                  |=> !loss_q)
      else $error("loss flag not cleared by completed return");

   timing_set_a: assert property (timing_violation_evt |=> timing_q)
      else $error("timing flag not set by violation");

   host_event_a: assert property (s_host_event |=> host_cl_irq_q)
      else $error("host clock-loss request missing after event");

   host_clear_a: assert property (rd_clk && !cl_event |=> !host_cl_irq_q)
      else $error("host clock-loss request not cleared by read");

   core_event_a: assert property (cl_event |=> (core_pend_q & $past(cfg_q.core_enable))
                                  == $past(cfg_q.core_enable))
      else $error("core clock-loss request not raised");

   core_mirror_a: assert property (ext_clk_valid
                                   |=> core_clkloss_irq == $past(core_pend_q))
      else $error("core clock-loss request not passed on");

   drv_on_a: assert property (!cksys_missing |=> cksys_drv_en)
      else $error("drivers held off without clock loss");

   cause_drv_a: assert property (s_first_req ##0 drv_off |=> status_q[ST_DRV_BIT])
      else $error("driver shutdown not latched");

   cause_spi_a: assert property (s_first_req ##0 spi_error |=> status_q[ST_SPI_BIT])
      else $error("serial error not latched");

   cause_sig_a: assert property (s_first_req ##0 code_sig_error_b
                                 |=> status_q[ST_SIG_B_BIT])
      else $error("code signature error not latched");

endmodule : irq_clk_combiner

// file: host_model.sv
// host controller model: reads and writes on the register port
`timescale 1ns/10ps
module host_model
   import irq_clk_pkg::*;
(
   input  wire logic                  core_clk,
   output logic      [REG_ADDR_W-1:0] reg_addr,
   output logic                       reg_wr_en,
   output logic                       reg_rd_en,
   output logic      [REG_DATA_W-1:0] reg_wdata,
   input  wire logic [REG_DATA_W-1:0] reg_rdata
);
   // idle port at time zero
   initial begin
      reg_addr  = 10'h000;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wdata = 16'h0000;
   end

   // write held across the taking edge; stale data inverted so nothing lingers
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(negedge core_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge core_clk);
      reg_wr_en = 1'b0;
      reg_wdata = ~d;
   endtask : wr

   // read answer lands one edge after the strobe is taken
   task automatic rd(input logic [9:0] a, output logic [15:0] d);
      @(negedge core_clk);
      reg_addr  = a;
      reg_rd_en = 1'b1;
      @(negedge core_clk);
      reg_rd_en = 1'b0;
      d         = reg_rdata;
   endtask : rd
endmodule : host_model

// file: tb_top.sv
// self-checking bench for the interrupt combiner and clock-loss register
`timescale 1ns/10ps
module tb_top
   import irq_clk_pkg::*;
;
   logic core_clk, reset_n, drv_off, spi_error, code_sig_error_a, code_sig_error_b;
   logic ref_clock_lost, switched_to_internal, switched_to_external, ext_clk_valid;
   logic cksys_missing, timing_violation_evt, reg_wr_en, reg_rd_en;
   logic host_irq_out_n, return_to_ext_ref, cksys_drv_en;
   logic [3:0]  short_halt, core_request, core_clkloss_ack, core_clkloss_irq;
   logic [9:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [11:0] r;
   logic [31:0] seed;
   int          n_errors, total_checks;

   irq_clk_combiner dut (.core_clk, .reset_n, .reg_addr, .reg_wr_en, .reg_rd_en,
      .reg_wdata, .reg_rdata, .short_halt, .core_request, .drv_off, .spi_error,
      .code_sig_error_a, .code_sig_error_b, .ref_clock_lost, .switched_to_internal,
      .switched_to_external, .ext_clk_valid, .cksys_missing, .timing_violation_evt,
      .core_clkloss_ack, .host_irq_out_n, .return_to_ext_ref, .core_clkloss_irq,
      .cksys_drv_en);
   host_model host (.core_clk, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
      .reg_rdata);

   // 40 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   // cause word expected for a source vector; bit 10 belongs to clock loss
   function automatic logic [15:0] ew(input logic [11:0] v);
      return {3'h0, v[11:10], 1'b0, v[9:0]};
   endfunction : ew

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rdc(input logic [9:0] a, input logic [15:0] exp);
      host.rd(a, d);
      chk(d, exp);
   endtask : rdc

   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask : wt

   task automatic src(input logic [11:0] v);
      {code_sig_error_b, code_sig_error_a, spi_error, drv_off, core_request, short_halt} = v;
   endtask : src

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test

   // watchdog: the sequence needs well under 1000 cycles
   initial begin
      #(4000 * 25);
      n_errors++;
      stop_test;
   end

   initial begin
      n_errors = 0;
      total_checks = 0;
      seed = 32'd63;
      reset_n = 1'b0;
      src(12'h000);
      {ref_clock_lost, switched_to_internal, switched_to_external} = 3'b000;
      {ext_clk_valid, cksys_missing, timing_violation_evt} = 3'b000;
      core_clkloss_ack = 4'h0;
      wt(5);
      reset_n = 1'b1;
      rdc(CLK_STATUS_ADDR, 16'h0000);
      rdc(IRQ_STATUS_ADDR, 16'h0000);
      // random source sets, all-sources corner first
      for (int i = 0; i < 20; i++) begin
         seed = xs(seed);
         r = (i == 0) ? 12'hfff : seed[11:0] | 12'h001;
         src(r);
         wt(1);
         chk({15'h0, host_irq_out_n}, 16'h0000);
         rdc(IRQ_STATUS_ADDR, ew(r));
         src(r | seed[23:12]);
         host.wr(IRQ_STATUS_ADDR, 16'hffff);
         rdc(IRQ_STATUS_ADDR, ew(r));
         src(12'h000);
         wt(1);
         chk({15'h0, host_irq_out_n}, 16'h0001);
         rdc(IRQ_STATUS_ADDR, 16'h0000);
      end
      // clock loss with every enable on, external clock still bad
      host.wr(CLK_STATUS_ADDR, 16'h00fc);
      ref_clock_lost = 1'b1;
      wt(1);
      ref_clock_lost = 1'b0;
      rdc(CLK_STATUS_ADDR, 16'h00fd);
      switched_to_internal = 1'b1;
      wt(1);
      switched_to_internal = 1'b0;
      wt(2);
      chk({12'h0, core_clkloss_irq}, 16'h0000);
      rdc(IRQ_STATUS_ADDR, 16'h0400);
      ext_clk_valid = 1'b1;
      wt(2);
      chk({12'h0, core_clkloss_irq}, 16'h000f);
      core_clkloss_ack = 4'hf;
      wt(1);
      core_clkloss_ack = 4'h0;
      wt(1);
      chk({12'h0, core_clkloss_irq}, 16'h0000);
      chk({15'h0, host_irq_out_n}, 16'h0000);
      rdc(CLK_STATUS_ADDR, 16'h00fd);
      wt(3);
      chk({15'h0, host_irq_out_n}, 16'h0001);
      // return request during loss raises a fresh event, then self-clears
      host.wr(CLK_STATUS_ADDR, 16'h00fe);
      wt(3);
      chk({14'h0, return_to_ext_ref, host_irq_out_n}, 16'h0002);
      rdc(CLK_STATUS_ADDR, 16'h00ff);
      switched_to_external = 1'b1;
      wt(1);
      switched_to_external = 1'b0;
      core_clkloss_ack = 4'hf;
      wt(1);
      core_clkloss_ack = 4'h0;
      chk({15'h0, return_to_ext_ref}, 16'h0000);
      rdc(CLK_STATUS_ADDR, 16'h00fc);
      // return request without loss is dropped
      host.wr(CLK_STATUS_ADDR, 16'h00fe);
      wt(2);
      chk({15'h0, return_to_ext_ref}, 16'h0000);
      // timing flag set by hardware, write-one clear
      timing_violation_evt = 1'b1;
      wt(1);
      timing_violation_evt = 1'b0;
      rdc(CLK_STATUS_ADDR, 16'h01fc);
      host.wr(CLK_STATUS_ADDR, 16'h01fc);
      rdc(CLK_STATUS_ADDR, 16'h00fc);
      // drivers forced off only while the system clock is missing
      cksys_missing = 1'b1;
      wt(2);
      chk({15'h0, cksys_drv_en}, 16'h0000);
      cksys_missing = 1'b0;
      wt(2);
      chk({15'h0, cksys_drv_en}, 16'h0001);
      // random core enable sets steer loss events, host request left off
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         host.wr(CLK_STATUS_ADDR, {8'h00, 1'b0, seed[3:0], 3'b000});
         switched_to_internal = 1'b1;
         wt(1);
         switched_to_internal = 1'b0;
         wt(2);
         chk({12'h0, core_clkloss_irq}, {12'h0, seed[3:0]});
         chk({15'h0, host_irq_out_n}, 16'h0001);
         core_clkloss_ack = 4'hf;
         wt(2);
         core_clkloss_ack = 4'h0;
      end
      // mid-run reset with the pin asserted and drivers forced off
      host.wr(CLK_STATUS_ADDR, 16'h0080);
      drv_off = 1'b1;
      cksys_missing = 1'b1;
      wt(2);
      chk({14'h0, host_irq_out_n, cksys_drv_en}, 16'h0000);
      reset_n = 1'b0;
      wt(2);
      chk({14'h0, host_irq_out_n, cksys_drv_en}, 16'h0003);
      chk({11'h0, return_to_ext_ref, core_clkloss_irq}, 16'h0000);
      reset_n = 1'b1;
      rdc(CLK_STATUS_ADDR, 16'h0000);
      rdc(IRQ_STATUS_ADDR, 16'h0100);
      chk({15'h0, cksys_drv_en}, 16'h0001);
      drv_off = 1'b0;
      cksys_missing = 1'b0;
      wt(2);
      chk({15'h0, host_irq_out_n}, 16'h0001);
      stop_test;
   end
endmodule : tb_top
